// >>> hdl/rxf_pkg.sv
// Constants, field layouts and types of the receive output framing block
package rxf_pkg;
  // Register byte offsets on the APB bus
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATE = 12'h004;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
  localparam logic [11:0] ADDR_INT_ENABLE = 12'h00c;
  localparam logic [11:0] ADDR_INT_CLEAR = 12'h010;
  // Control register layout
  localparam int CTRL_W = 9;
  localparam int CTRL_DEC_LSB = 0;
  localparam int CTRL_FMODE_BIT = 2;
  localparam int CTRL_HALF_BIT = 3;
  localparam int CTRL_CKSEL_LSB = 4;
  localparam int CTRL_FON_BIT = 6;
  localparam int CTRL_PAT_BIT = 7;
  localparam int CTRL_BIST_BIT = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [1:0] DEC_BYPASS = 2'h0;
  localparam logic [1:0] CKSEL_REF = 2'h0;
  // Interrupt bit layout
  localparam int INT_W = 4;
  localparam int INT_FRAMING = 0;
  localparam int INT_SYNC_LOST = 1;
  localparam int INT_VIOL = 2;
  localparam int INT_ADJUST = 3;
  localparam logic [3:0] INT_RESET = 4'h0;
  // Character status codes, decoder running
  localparam logic [2:0] ST_NORMAL = 3'h0;
  localparam logic [2:0] ST_SPECIAL = 3'h1;
  localparam logic [2:0] ST_ELASTIC = 3'h2;
  localparam logic [2:0] ST_FRAMING = 3'h3;
  localparam logic [2:0] ST_VIOL = 3'h4;
  localparam logic [2:0] ST_SYNC_LOST = 3'h5;
  localparam logic [2:0] ST_DISPARITY = 3'h6;
  // Character status codes, receive self-test running
  localparam logic [2:0] BIST_DATA = 3'h0;
  localparam logic [2:0] BIST_CMD = 3'h1;
  localparam logic [2:0] BIST_LAST_GOOD = 3'h2;
  localparam logic [2:0] BIST_LAST_BAD = 3'h4;
  localparam logic [2:0] BIST_START = 3'h5;
  localparam logic [2:0] BIST_ERROR = 3'h6;
  // Framing patterns, bit 0 is symbol bit a
  localparam logic [6:0] COMMA_POS = 7'h7c;
  localparam logic [6:0] COMMA_NEG = 7'h03;
  localparam logic [9:0] FULL_POS = 10'h17c;
  localparam logic [9:0] FULL_NEG = 10'h283;
  // Low phase forced on the output clock when it is stretched
  localparam int CLK_PERIOD_NS = 5;
  localparam int STRETCH_LOW_NS = 10;
  localparam int STRETCH_CYC = (STRETCH_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] STRETCH_LAST = 3'(STRETCH_CYC - 1);
  localparam int SYNC_W = 29;
  typedef enum logic [0:0] {CK_RUN, CK_STRETCH} rxf_ck_state_t;
endpackage

// >>> hdl/rxf_status_encode.sv
// Priority encoder of the three character status bits
`timescale 1ns/1ps
`default_nettype none
module rxf_status_encode (
  input wire logic bist_mode_in, // Receive self-test enabled
  input wire logic framing_in, // Framing character seen
  input wire logic special_in, // Valid special code
  input wire logic code_viol_in, // Undecodable character
  input wire logic disparity_in, // Running disparity error
  input wire logic elastic_in, // Elasticity buffer error
  input wire logic sync_lost_in, // Synchronisation lost
  input wire logic bist_start_in, // Self-test not yet comparing
  input wire logic bist_error_in, // Self-test mismatch
  input wire logic bist_last_bad_in, // Last self-test character bad
  input wire logic bist_last_good_in, // Last self-test character good
  input wire logic bist_cmd_in, // Self-test command compared
  output logic [2:0] code_out // Highest priority status
);
  // Only the most severe condition is reported; valid codes come last
  always_comb
  begin
    if (bist_mode_in)
    begin
      if (bist_start_in) code_out = rxf_pkg::BIST_START;
      else if (bist_error_in) code_out = rxf_pkg::BIST_ERROR;
      else if (bist_last_bad_in) code_out = rxf_pkg::BIST_LAST_BAD;
      else if (bist_last_good_in) code_out = rxf_pkg::BIST_LAST_GOOD;
      else if (bist_cmd_in) code_out = rxf_pkg::BIST_CMD;
      else code_out = rxf_pkg::BIST_DATA;
    end
    else if (sync_lost_in) code_out = rxf_pkg::ST_SYNC_LOST;
    else if (elastic_in) code_out = rxf_pkg::ST_ELASTIC;
    else if (code_viol_in) code_out = rxf_pkg::ST_VIOL;
    else if (framing_in) code_out = rxf_pkg::ST_FRAMING;
    else if (disparity_in) code_out = rxf_pkg::ST_DISPARITY;
    else if (special_in) code_out = rxf_pkg::ST_SPECIAL;
    else code_out = rxf_pkg::ST_NORMAL;
  end
endmodule
`default_nettype wire

// >>> hdl/rxf_output_framer.sv
// Receive channel output register formatter and framing aligner
// What this block does
// - Bypass mode: a,b on status bits 1,0; c..j on data 0..7; detect on status 2.
// - Framing detect high only for the selected framing character, else low.
// - Low-latency, half rate, non-reference clock: stretch clock so it rises on framing.
// - Standard framer, half rate: clock untouched, add or drop one pipeline stage.
// - Boundary adjustment happens only while the framer is on.
// - Framer off: no adjustment; detect may sit on the complementary clock edge.
// - Decoder on: every character carries three status bits.
// - Self-test status shown whenever self-test runs, decoder on or bypassed.
// - Only the highest priority condition of a character is reported.
// - Code 000 marks a normal data character.
// - During self-test code 000 marks a correctly compared data character.
// - Code 001 marks a valid special code, or a compared command in self-test.
// - Decoder mid or high: data outputs carry decoded data, status the code.
// - Code 101 marks a character lost to synchronisation loss.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rxf_output_framer (
  input wire logic clock_in, // 200 MHz system clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic link_clk_in, // Character clock of the receive path
  input wire logic [9:0] raw_symbol_in, // Framed 10-bit symbol, bit 0 is a
  input wire logic [7:0] dec_data_in, // Decoded data byte
  input wire logic special_in, // Valid special code
  input wire logic code_viol_in, // Undecodable character
  input wire logic disparity_in, // Running disparity error
  input wire logic elastic_in, // Elasticity buffer error
  input wire logic sync_lost_in, // Synchronisation lost
  input wire logic bist_start_in, // Self-test not yet comparing
  input wire logic bist_error_in, // Self-test mismatch
  input wire logic bist_last_bad_in, // Last self-test character bad
  input wire logic bist_last_good_in, // Last self-test character good
  input wire logic bist_cmd_in, // Self-test command compared
  output logic [7:0] rx_data_out, // Output register data
  output logic [2:0] rx_status_bits_out, // Output register status
  output logic framing_char_detect_out, // Shown character is framing
  output logic rx_output_clock_true_out, // Output clock
  output logic rx_output_clock_comp_out, // Complementary output clock
  output logic irq_out // Level interrupt
);
  logic [8:0] ctrl_r;
  logic [3:0] int_status_r, int_enable_r;
  logic [28:0] meta_r, sync_r;
  logic link_prev_r, char_stb;
  logic [9:0] sym;
  logic [7:0] dat;
  logic bypass, half, low_lat, framer_on, bist_mode;
  logic det_new, would_rise, wrong, adj_std, adj_stretch;
  logic [2:0] code_new;
  logic [21:0] word_new, stage_r, hold_r, word_sel;
  logic delay_sel_r;
  logic [9:0] raw_shown_r;
  rxf_pkg::rxf_ck_state_t ck_state_r;
  logic [2:0] cnt_r;
  logic load_now, load_q;
  logic [3:0] events;
  logic apb_acc, apb_wr;
  logic [31:0] rd_val;
  logic rd_err;

  // Compare a symbol against the selected framing pattern
  function automatic logic frame_match(input logic [9:0] s, input logic full);
    if (full)
      frame_match = (s == rxf_pkg::FULL_POS) || (s == rxf_pkg::FULL_NEG);
    else
      frame_match = (s[6:0] == rxf_pkg::COMMA_POS) || (s[6:0] == rxf_pkg::COMMA_NEG);
  endfunction

  // Control fields
  assign bypass = ctrl_r[rxf_pkg::CTRL_DEC_LSB +: 2] == rxf_pkg::DEC_BYPASS;
  assign low_lat = !ctrl_r[rxf_pkg::CTRL_FMODE_BIT];
  assign half = ctrl_r[rxf_pkg::CTRL_HALF_BIT];
  assign framer_on = ctrl_r[rxf_pkg::CTRL_FON_BIT];
  assign bist_mode = ctrl_r[rxf_pkg::CTRL_BIST_BIT];

  // Two-flop synchroniser for everything arriving from the link side
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      link_prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= {link_clk_in, raw_symbol_in, dec_data_in, special_in, code_viol_in,
                 disparity_in, elastic_in, sync_lost_in, bist_start_in, bist_error_in,
                 bist_last_bad_in, bist_last_good_in, bist_cmd_in};
      sync_r <= meta_r;
      link_prev_r <= sync_r[28];
    end
  end

  // Take the character at the link falling edge, mid-character, where data is settled
  assign char_stb = link_prev_r && !sync_r[28];
  assign sym = sync_r[27:18];
  assign dat = sync_r[17:10];
  assign det_new = frame_match(sym, ctrl_r[rxf_pkg::CTRL_PAT_BIT]);

  rxf_status_encode u_enc (
    .bist_mode_in(bist_mode),
    .framing_in(det_new),
    .special_in(sync_r[9]),
    .code_viol_in(sync_r[8]),
    .disparity_in(sync_r[7]),
    .elastic_in(sync_r[6]),
    .sync_lost_in(sync_r[5]),
    .bist_start_in(sync_r[4]),
    .bist_error_in(sync_r[3]),
    .bist_last_bad_in(sync_r[2]),
    .bist_last_good_in(sync_r[1]),
    .bist_cmd_in(sync_r[0]),
    .code_out(code_new)
  );

  // Word layout: raw symbol, detect, data byte, status bits
  always_comb
  begin
    if (bypass && !bist_mode)
      word_new = {sym, det_new, sym[9:2], det_new, sym[0], sym[1]};
    else if (bypass)
      word_new = {sym, det_new, sym[9:2], code_new};
    else
      word_new = {sym, det_new, dat, code_new};
  end

  // Alignment decision for a framing character now arriving
  assign would_rise = !half || !rx_output_clock_true_out;
  assign wrong = det_new && (delay_sel_r ? would_rise : !would_rise);
  assign adj_std = char_stb && half && framer_on && !low_lat && wrong;
  assign adj_stretch = char_stb && half && framer_on && low_lat && !would_rise
                       && det_new && (ctrl_r[rxf_pkg::CTRL_CKSEL_LSB +: 2] != rxf_pkg::CKSEL_REF);
  // The select flips in the same load, so a dropped stage shows the framing char at once
  assign word_sel = (delay_sel_r ^ adj_std) ? stage_r : word_new;
  assign load_now = (char_stb && !adj_stretch && ck_state_r == rxf_pkg::CK_RUN)
                    || (ck_state_r == rxf_pkg::CK_STRETCH && cnt_r == 3'h0);

  // One pipeline stage, added or dropped by the standard framer
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      stage_r <= '0;
      delay_sel_r <= 1'b0;
    end
    else if (char_stb)
    begin
      stage_r <= word_new;
      if (low_lat)
        delay_sel_r <= 1'b0;
      else if (adj_std)
        delay_sel_r <= !delay_sel_r;
    end
  end

  // Output clock: half rate toggles per character, stretched low in low-latency mode
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ck_state_r <= rxf_pkg::CK_RUN;
      cnt_r <= 3'h0;
      hold_r <= '0;
      rx_output_clock_true_out <= 1'b0;
    end
    else if (ck_state_r == rxf_pkg::CK_STRETCH)
    begin
      if (cnt_r == 3'h0)
      begin
        ck_state_r <= rxf_pkg::CK_RUN;
        rx_output_clock_true_out <= 1'b1;
      end
      else
        cnt_r <= cnt_r - 3'h1;
    end
    else if (adj_stretch)
    begin
      ck_state_r <= rxf_pkg::CK_STRETCH;
      cnt_r <= rxf_pkg::STRETCH_LAST;
      hold_r <= word_new;
      rx_output_clock_true_out <= 1'b0;
    end
    else if (char_stb)
      rx_output_clock_true_out <= half ? !rx_output_clock_true_out : 1'b1;
    else if (!half && !link_prev_r && sync_r[28])
      rx_output_clock_true_out <= 1'b0;
  end
  assign rx_output_clock_comp_out = !rx_output_clock_true_out;

  // Data and status loaded as one pair
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      rx_data_out <= 8'h00;
      rx_status_bits_out <= 3'h0;
      framing_char_detect_out <= 1'b0;
      raw_shown_r <= 10'h000;
      load_q <= 1'b0;
    end
    else
    begin
      load_q <= load_now;
      if (load_now)
      begin
        {raw_shown_r, framing_char_detect_out, rx_data_out, rx_status_bits_out} <=
          (ck_state_r == rxf_pkg::CK_STRETCH) ? hold_r : word_sel;
      end
    end
  end

  // Events of each accepted character
  assign events[rxf_pkg::INT_FRAMING] = char_stb && det_new;
  assign events[rxf_pkg::INT_SYNC_LOST] = char_stb && !bist_mode && sync_r[5];
  assign events[rxf_pkg::INT_VIOL] = char_stb && !bist_mode && (sync_r[8] || sync_r[7]);
  assign events[rxf_pkg::INT_ADJUST] = adj_std || adj_stretch;

  // APB: one wait state so read data comes from a flop
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite && pready;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr)
      rxf_pkg::ADDR_CTRL: rd_val = {23'h000000, ctrl_r};
      rxf_pkg::ADDR_STATE: rd_val = {26'h0000000, rx_output_clock_true_out, delay_sel_r,
                                     framing_char_detect_out, rx_status_bits_out};
      rxf_pkg::ADDR_INT_STATUS: rd_val = {28'h0000000, int_status_r};
      rxf_pkg::ADDR_INT_ENABLE: rd_val = {28'h0000000, int_enable_r};
      rxf_pkg::ADDR_INT_CLEAR: rd_val = 32'h0000_0000;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_acc && !pready;
      prdata <= (apb_acc && !pready && !pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= apb_acc && !pready && rd_err;
    end
  end

  // Writable registers
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_r <= rxf_pkg::CTRL_RESET;
      int_enable_r <= rxf_pkg::INT_RESET;
    end
    else if (apb_wr && paddr == rxf_pkg::ADDR_CTRL)
      ctrl_r <= pwdata[8:0];
    else if (apb_wr && paddr == rxf_pkg::ADDR_INT_ENABLE)
      int_enable_r <= pwdata[3:0];
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      int_status_r <= rxf_pkg::INT_RESET;
    else if (apb_wr && paddr == rxf_pkg::ADDR_INT_CLEAR)
      int_status_r <= (int_status_r & ~pwdata[3:0]) | events;
    else
      int_status_r <= int_status_r | events;
  end
  assign irq_out = |(int_status_r & int_enable_r);

  property p_bypass_map;
    @(posedge clock_in) disable iff (!rst_n_in)
    load_q && $past(bypass) && !$past(bist_mode) |->
      rx_status_bits_out[2] == framing_char_detect_out
      && rx_data_out == raw_shown_r[9:2] && rx_status_bits_out[1] == raw_shown_r[0];
  endproperty
  a_bypass_map: assert property (p_bypass_map) else $error("bypass mapping wrong");
  property p_det_match;
    @(posedge clock_in) disable iff (!rst_n_in)
    load_q && $stable(ctrl_r) |->
      framing_char_detect_out == frame_match(raw_shown_r, ctrl_r[rxf_pkg::CTRL_PAT_BIT]);
  endproperty
  a_det_match: assert property (p_det_match) else $error("detect flag mismatch");
  property p_stretch;
    @(posedge clock_in) disable iff (!rst_n_in)
    adj_stretch |=> !rx_output_clock_true_out [*2] ##1
      (rx_output_clock_true_out && framing_char_detect_out);
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch not aligned");
  property p_std_clock;
    @(posedge clock_in) disable iff (!rst_n_in)
    adj_std |=> rx_output_clock_true_out != $past(rx_output_clock_true_out)
      && delay_sel_r != $past(delay_sel_r);
  endproperty
  a_std_clock: assert property (p_std_clock) else $error("standard adjust wrong");
  property p_adj_on;
    @(posedge clock_in) disable iff (!rst_n_in)
    (adj_std || adj_stretch) |-> framer_on;
  endproperty
  a_adj_on: assert property (p_adj_on) else $error("adjust with framer off");
  property p_off_hold;
    @(posedge clock_in) disable iff (!rst_n_in)
    !framer_on && !low_lat && ck_state_r == rxf_pkg::CK_RUN |=> $stable(delay_sel_r)
      && ck_state_r == rxf_pkg::CK_RUN;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("boundary moved with framer off");
  property p_bist_start;
    @(posedge clock_in) disable iff (!rst_n_in)
    char_stb && bist_mode && sync_r[4] |-> code_new == rxf_pkg::BIST_START;
  endproperty
  a_bist_start: assert property (p_bist_start) else $error("self-test status lost");
  property p_prio;
    @(posedge clock_in) disable iff (!rst_n_in)
    char_stb && !bist_mode && sync_r[7] |->
      code_new != rxf_pkg::ST_NORMAL && code_new != rxf_pkg::ST_SPECIAL;
  endproperty
  a_prio: assert property (p_prio) else $error("disparity error shown valid");
  property p_normal;
    @(posedge clock_in) disable iff (!rst_n_in)
    char_stb && !bist_mode && !det_new && sync_r[9:5] == 5'h00 |->
      code_new == rxf_pkg::ST_NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("normal code wrong");
  property p_sync_lost;
    @(posedge clock_in) disable iff (!rst_n_in)
    char_stb && !bist_mode && sync_r[5] |-> code_new == rxf_pkg::ST_SYNC_LOST;
  endproperty
  a_sync_lost: assert property (p_sync_lost) else $error("sync loss not top");
  property p_irq;
    @(posedge clock_in) disable iff (!rst_n_in)
    events[rxf_pkg::INT_FRAMING] && int_enable_r[rxf_pkg::INT_FRAMING] |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missed");
  c_stretch: cover property (@(posedge clock_in) disable iff (!rst_n_in) adj_stretch);
  c_std: cover property (@(posedge clock_in) disable iff (!rst_n_in) adj_std);
  c_sync: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    events[rxf_pkg::INT_SYNC_LOST]);
  c_irq: cover property (@(posedge clock_in) disable iff (!rst_n_in) $rose(irq_out));
endmodule
`default_nettype wire

// >>> verification/rxf_link_model.sv
// Receive-path source model: link clock, framed symbols and condition flags
`timescale 1ns/1ps
`default_nettype none
module rxf_link_model (
  input wire logic clock_in, // System clock, launch timing
  output logic link_clk_out, // Free-running character clock
  output logic [9:0] raw_symbol_out, // Framed symbol, bit 0 is a
  output logic [7:0] dec_data_out, // Decoded byte
  output logic [9:0] cond_out // Condition and self-test flags
);
  // Recovered clock runs free, as the real path never gates it
  initial
  begin
    link_clk_out = 1'b0;
    forever #32 link_clk_out = ~link_clk_out;
  end
  initial
  begin
    raw_symbol_out = 10'h000;
    dec_data_out = 8'h00;
    cond_out = 10'h000;
  end
  // Launch after link rise, hold over the fall, then disturb with a non-framing value
  task automatic send(input logic [9:0] sym, input logic [7:0] dat, input logic [9:0] cond);
    begin
      @(posedge link_clk_out);
      @(posedge clock_in);
      raw_symbol_out <= sym;
      dec_data_out <= dat;
      cond_out <= cond;
      @(negedge link_clk_out);
      repeat (8) @(posedge clock_in);
      raw_symbol_out <= sym ^ 10'h155;
      dec_data_out <= ~dat;
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking testbench of the receive output framing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  logic clock_in, rst_n_in, psel, penable, pwrite, pready, pslverr, link_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] sym, cond;
  logic [7:0] dat, rx_data;
  logic [2:0] rx_st;
  logic det, ck_t, ck_c, irq, err;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  rxf_link_model u_link (.clock_in(clock_in), .link_clk_out(link_clk), .raw_symbol_out(sym),
    .dec_data_out(dat), .cond_out(cond));
  rxf_output_framer u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk_in(link_clk), .raw_symbol_in(sym),
    .dec_data_in(dat), .special_in(cond[0]), .code_viol_in(cond[1]), .disparity_in(cond[2]),
    .elastic_in(cond[3]), .sync_lost_in(cond[4]), .bist_start_in(cond[5]),
    .bist_error_in(cond[6]), .bist_last_bad_in(cond[7]), .bist_last_good_in(cond[8]),
    .bist_cmd_in(cond[9]), .rx_data_out(rx_data), .rx_status_bits_out(rx_st),
    .framing_char_detect_out(det), .rx_output_clock_true_out(ck_t),
    .rx_output_clock_comp_out(ck_c), .irq_out(irq));
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // Hang guard, well above the thousand or so cycles the run needs
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; a dead slave is caught by the cycle ceiling
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clock_in);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, exp)
    `CHK(err, exp_err)
  endtask
  // Send one character and compare the whole output register
  task automatic chk_char(input logic [9:0] s, input logic [7:0] d, input logic [9:0] c,
    input logic [7:0] ed, input logic [2:0] es, input logic edet);
    u_link.send(s, d, c);
    `CHK(rx_data, ed)
    `CHK(rx_st, es)
    `CHK(det, edet)
  endtask
  // Bypass: a,b swapped onto status 1,0, c..j on data, detect on status 2
  task automatic chk_byp(input logic [9:0] s, input logic edet);
    chk_char(s, 8'h3c, 10'h000, s[9:2], {edet, s[0], s[1]}, edet);
  endtask
  // With the framer on, framing char must sit on a rising output clock, now or, standard framer only, after the next character
  task automatic chk_align(input logic std, input logic on);
    logic ok_a;
    u_link.send(10'h17c, 8'h00, 10'h000);
    ok_a = det && ck_t;
    @(negedge link_clk);
    repeat (8) @(posedge clock_in);
    `CHK(!on || ok_a || (std && det && ck_t), 1'b1)
  endtask
  task automatic chk_dec(input logic [9:0] c, input logic [2:0] code);
    chk_char(10'h0f5, 8'hc3, c, 8'hc3, code, 1'b0);
  endtask
  task automatic t_regs();
    rd_chk(rxf_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
    rd_chk(rxf_pkg::ADDR_INT_ENABLE, 32'h0000_0000, 1'b0);
    rd_chk(rxf_pkg::ADDR_INT_STATUS, 32'h0000_0000, 1'b0);
    apb(1'b1, rxf_pkg::ADDR_INT_ENABLE, 32'hffff_ffff);
    rd_chk(rxf_pkg::ADDR_INT_ENABLE, 32'h0000_000f, 1'b0);
    apb(1'b1, rxf_pkg::ADDR_INT_ENABLE, 32'h0000_0000);
    apb(1'b1, rxf_pkg::ADDR_CTRL, 32'hffff_fe36);
    rd_chk(rxf_pkg::ADDR_CTRL, 32'h0000_0036, 1'b0);
    rd_chk(rxf_pkg::ADDR_INT_CLEAR, 32'h0000_0000, 1'b0);
    rd_chk(12'h014, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h014, 32'h0000_0001);
    `CHK(err, 1'b1)
  endtask
  task automatic t_bypass();
    apb(1'b1, rxf_pkg::ADDR_CTRL, 32'h0000_0040);
    chk_byp(10'h2a5, 1'b0);
    chk_byp(10'h15a, 1'b0);
    chk_byp(10'h3fe, 1'b0);
    chk_byp(10'h001, 1'b0);
  endtask
  // Both comma polarities, then a near miss that only the full pattern rejects
  task automatic t_detect();
    apb(1'b1, rxf_pkg::ADDR_INT_CLEAR, 32'h0000_000f);
    apb(1'b1, rxf_pkg::ADDR_INT_ENABLE, 32'h0000_0001);
    chk_byp(10'h17c, 1'b1);
    chk_byp(10'h283, 1'b1);
    chk_byp(10'h37c, 1'b1);
    chk_byp(10'h0f5, 1'b0);
    apb(1'b1, rxf_pkg::ADDR_CTRL, 32'h0000_00c0);
    chk_byp(10'h17c, 1'b1);
    chk_byp(10'h283, 1'b1);
    chk_byp(10'h37c, 1'b0);
    rd_chk(rxf_pkg::ADDR_INT_STATUS, 32'h0000_0001, 1'b0);
    `CHK(irq, 1'b1)
    apb(1'b1, rxf_pkg::ADDR_INT_ENABLE, 32'h0000_0000);
    `CHK(irq, 1'b0)
    apb(1'b1, rxf_pkg::ADDR_INT_ENABLE, 32'h0000_0001);
    `CHK(irq, 1'b1)
    apb(1'b1, rxf_pkg::ADDR_INT_CLEAR, 32'h0000_0001);
    `CHK(irq, 1'b0)
    rd_chk(rxf_pkg::ADDR_INT_STATUS, 32'h0000_0000, 1'b0);
  endtask
  // Overlapping conditions: only the strongest one may show
  task automatic t_decoder();
    apb(1'b1, rxf_pkg::ADDR_CTRL, 32'h0000_0001);
    chk_dec(10'h000, 3'h0);
    chk_dec(10'h001, 3'h1);
    chk_dec(10'h010, 3'h5);
    chk_dec(10'h005, 3'h6);
    chk_dec(10'h003, 3'h4);
    chk_dec(10'h01a, 3'h5);
    chk_dec(10'h008, 3'h2);
  endtask
  // Self-test codes shown with the decoder bypassed and running alike
  task automatic t_bist();
    apb(1'b1, rxf_pkg::ADDR_CTRL, 32'h0000_0100);
    chk_char(10'h2a5, 8'h00, 10'h000, 8'ha9, 3'h0, 1'b0);
    chk_char(10'h2a5, 8'h00, 10'h200, 8'ha9, 3'h1, 1'b0);
    chk_char(10'h2a5, 8'h00, 10'h220, 8'ha9, 3'h5, 1'b0);
    apb(1'b1, rxf_pkg::ADDR_CTRL, 32'h0000_0101);
    chk_dec(10'h200, 3'h1);
    chk_dec(10'h140, 3'h6);
    chk_dec(10'h080, 3'h4);
  endtask
  // Half rate: stretch, standard pipeline shift, then framer off with no adjust
  task automatic t_align();
    logic [31:0] m;
    for (int i = 0; i < 3; i++)
    begin
      m = (i == 0) ? 32'h0000_0058 : ((i == 1) ? 32'h0000_004c : 32'h0000_000c);
      apb(1'b1, rxf_pkg::ADDR_CTRL, m);
      apb(1'b1, rxf_pkg::ADDR_INT_CLEAR, 32'h0000_000f);
      repeat (2) chk_align(m[2], m[6]);
      rd_chk(rxf_pkg::ADDR_INT_STATUS, m[6] ? 32'h0000_0009 : 32'h0000_0001, 1'b0);
    end
  endtask
  initial
  begin
    rst_n_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge clock_in);
    `CHK(rx_data, 8'h00)
    `CHK(ck_c, 1'b1)
    `CHK(irq, 1'b0)
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    t_regs();
    t_bypass();
    t_detect();
    t_decoder();
    t_bist();
    t_align();
    test_done();
  end
endmodule
`default_nettype wire
